// *** rtl/ife_exec.sv ***
`timescale 1ns/100ps

// Operation
// - Clear fetched word at T0, opcode latch at T1, load opcode latch at T2.
// - Opcode 100001 raises group decode and qualifier from T3 to next T0.
// - Timed enable with bits 8..6 gives the set-flag strobe at T3.
// - Bits 5..0 gated by timed enable form the select code for cards.
// - Set strobe sets the selected flag; the card keeps it set.
// - Timed enable with bit 9 gives the clear-flag strobe at T4.
// - Clear strobe clears the selected flag; the card resets it.
// - At T6/T7 counter to R bus, inject, add; at T7 store into counter and address.
// - After the counter update, set the fetch phase for the next instruction.
// - Halt at T6/T7 adds one, resets run latch, sets fetch phase.
// - Timed enable with bits 8..6 forms the skip test strobe to the cards.
// - Skip response sets carry latch at T4/T5; carry-in follows at T6/T7.
// - Carry-in with injection advances by two, injection alone by one, no injection (loop switch) by zero.
// - Loop switch suppresses injection so the instruction repeats.
// - Word 103001 is halt; looping halt repeats on every run press.
// - Words 1021XX set and 1031XX clear the flag at select code XX.
// - Skip-if-clear skips the next instruction exactly when the flag is clear and the loop switch is off.
// - Halt request at T3 clears run latch one at T5, run latch two at T7.
// - Halt with bit 9 also clears the selected flag.
// - Next phase is fetch, or interrupt phase when an interrupt is pending and the interrupt phase is not already set.
module ife_exec (
    // Clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_n_i,
    // Memory and front panel
    input  wire logic [ife_pkg::WORD_W-1:0]  mem_word_i,
    input  wire logic                        run_press_i,
    input  wire logic                        loop_switch_i,
    input  wire logic                        interrupt_pending_i,
    // Interface cards
    input  wire logic                        flag_skip_response_i,
    output logic      [ife_pkg::SEL_W-1:0]   select_code_o,
    output logic                             set_flag_strobe_o,
    output logic                             clear_flag_strobe_o,
    output logic                             skip_test_strobe_o,
    // Decode and datapath control
    output logic                             io_group_decode_o,
    output logic                             opcode_qualifier_o,
    output logic                             halt_request_o,
    output logic                             counter_to_r_bus_o,
    output logic                             increment_injection_o,
    output logic                             adder_function_select_o,
    output logic                             carry_in_signal_o,
    output logic                             counter_store_strobe_o,
    output logic                             address_store_strobe_o,
    // Machine state
    output logic      [ife_pkg::SLOT_W-1:0]  slot_o,
    output logic      [ife_pkg::ADDR_W-1:0]  program_counter_o,
    output logic      [ife_pkg::ADDR_W-1:0]  memory_address_o,
    output logic                             fetch_phase_o,
    output logic                             interrupt_phase_o,
    output logic                             run_latch_one_o,
    output logic                             run_latch_two_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [ife_pkg::WORD_W-1:0] fetched_word_latch_q;
    logic [ife_pkg::OPC_W-1:0]  opcode_latch_q;
    logic [ife_pkg::SLOT_W-1:0] slot_q;
    logic [ife_pkg::ADDR_W-1:0] pc_q;
    logic [ife_pkg::ADDR_W-1:0] pc_d;
    logic [ife_pkg::ADDR_W-1:0] mar_q;
    logic                       carry_latch_q;
    logic                       halt_pend_q;
    logic                       run_latch_one_q;
    logic                       run_latch_two_q;
    logic                       fetch_phase_latch_q;
    logic                       int_phase_q;
    logic                       run_meta_q;
    logic                       run_sync_q;
    logic                       run_prev_q;
    logic                       loop_meta_q;
    logic                       loop_sync_q;

    wire logic       active;
    wire logic       run_rise;
    wire logic       t0;
    wire logic       t1;
    wire logic       t2;
    wire logic       t3;
    wire logic       t4;
    wire logic       t5;
    wire logic       t6t7;
    wire logic       t7;
    wire logic       iog_match;
    wire logic       iog_window;
    wire logic       io_group_enable_timed;
    wire logic [2:0] sub_op;
    wire logic       halt_op;
    wire logic       set_flag_op;
    wire logic       skip_if_flag_clear_op;
    wire logic       inject;
    wire logic [1:0] pc_step;

    function automatic logic at_slot(input logic [ife_pkg::SLOT_W-1:0] cur,
                                     input logic [ife_pkg::SLOT_W-1:0] want,
                                     input logic                       run);
        at_slot = run && (cur == want);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Front-panel pins come from outside the clock domain
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            run_meta_q  <= 1'b0;
            run_sync_q  <= 1'b0;
            run_prev_q  <= 1'b0;
            loop_meta_q <= 1'b0;
            loop_sync_q <= 1'b0;
        end else begin
            run_meta_q  <= run_press_i;
            run_sync_q  <= run_meta_q;
            run_prev_q  <= run_sync_q;
            loop_meta_q <= loop_switch_i;
            loop_sync_q <= loop_meta_q;
        end
    end

    assign run_rise = run_sync_q && !run_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Slot decode
    assign active = run_latch_two_q;
    assign t0     = at_slot(slot_q, ife_pkg::T0, active);
    assign t1     = at_slot(slot_q, ife_pkg::T1, active);
    assign t2     = at_slot(slot_q, ife_pkg::T2, active);
    assign t3     = at_slot(slot_q, ife_pkg::T3, active);
    assign t4     = at_slot(slot_q, ife_pkg::T4, active);
    assign t5     = at_slot(slot_q, ife_pkg::T5, active);
    assign t7     = at_slot(slot_q, ife_pkg::T7, active);
    assign t6t7   = at_slot(slot_q, ife_pkg::T6, active) || t7;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction decode
    // The opcode latch still holds the old opcode at the following T0
    assign iog_match  = (opcode_latch_q & ife_pkg::IOG_MASK) == ife_pkg::IOG_PATTERN;
    assign iog_window = active && fetch_phase_latch_q && (slot_q >= ife_pkg::T3 || t0);
    assign io_group_enable_timed = iog_match && iog_window;

    assign sub_op                = fetched_word_latch_q[ife_pkg::SUB_HI:ife_pkg::SUB_LO];
    assign halt_op               = sub_op == ife_pkg::SUB_HALT;
    assign set_flag_op           = sub_op == ife_pkg::SUB_FLAG;
    assign skip_if_flag_clear_op = sub_op == ife_pkg::SUB_SKPC;

    assign io_group_decode_o  = io_group_enable_timed;
    assign opcode_qualifier_o = io_group_enable_timed;
    assign halt_request_o     = io_group_enable_timed && halt_op && t3;

    // Cards see a zero select code outside the enable window
    assign select_code_o = io_group_enable_timed ?
        fetched_word_latch_q[ife_pkg::SEL_HI:ife_pkg::SEL_LO] : 6'h00;
    assign set_flag_strobe_o   = io_group_enable_timed && set_flag_op && t3;
    // Bit 9 clears on any group word, halt included
    assign clear_flag_strobe_o = io_group_enable_timed &&
        fetched_word_latch_q[ife_pkg::CLR_BIT] && t4;
    assign skip_test_strobe_o  = io_group_enable_timed && skip_if_flag_clear_op &&
        (t3 || t4 || t5);

    ////////////////////////////////////////////////////////////////////////////
    // Counter update path
    assign counter_to_r_bus_o      = t6t7 && fetch_phase_latch_q;
    assign adder_function_select_o = t6t7 && fetch_phase_latch_q;
    // Loop mode drops the injection so the same word is fetched again
    assign inject                  = t6t7 && fetch_phase_latch_q && !loop_sync_q;
    assign increment_injection_o   = inject;
    assign carry_in_signal_o       = t6t7 && carry_latch_q;
    assign counter_store_strobe_o  = t7 && fetch_phase_latch_q;
    assign address_store_strobe_o  = t7 && fetch_phase_latch_q;
    // Carry only counts when riding on the injection
    assign pc_step = {inject && carry_latch_q, inject && !carry_latch_q};
    assign pc_d    = pc_q + {{(ife_pkg::ADDR_W-2){1'b0}}, pc_step};

    ////////////////////////////////////////////////////////////////////////////
    // Word latches and slot counter
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            fetched_word_latch_q <= ife_pkg::WORD_RST;
            opcode_latch_q       <= ife_pkg::OPC_RST;
            slot_q               <= ife_pkg::SLOT_RST;
        end else begin
            if (t0) begin
                fetched_word_latch_q <= ife_pkg::WORD_RST;
            end else if (t1) begin
                fetched_word_latch_q <= mem_word_i;
            end
            if (t1) begin
                opcode_latch_q <= ife_pkg::OPC_RST;
            end else if (t2 && fetch_phase_latch_q) begin
                opcode_latch_q <=
                    fetched_word_latch_q[ife_pkg::OPC_HI:ife_pkg::OPC_LO];
            end
            if (active) begin
                slot_q <= slot_q + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Carry latch, program counter and address register
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            carry_latch_q <= 1'b0;
            pc_q          <= ife_pkg::ADDR_RST;
            mar_q         <= ife_pkg::ADDR_RST;
        end else begin
            if (skip_test_strobe_o && flag_skip_response_i && (t4 || t5)) begin
                carry_latch_q <= 1'b1;
            end else if (t0) begin
                carry_latch_q <= 1'b0;
            end
            if (counter_store_strobe_o) begin
                pc_q  <= pc_d;
                mar_q <= pc_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Run latches and phase
    // A run press while halted restarts at T0, so a looping halt runs again
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            halt_pend_q         <= 1'b0;
            run_latch_one_q     <= 1'b0;
            run_latch_two_q     <= 1'b0;
            fetch_phase_latch_q <= 1'b1;
            int_phase_q         <= 1'b0;
        end else begin
            if (halt_request_o) begin
                halt_pend_q <= 1'b1;
            end else if (t0) begin
                halt_pend_q <= 1'b0;
            end
            if (!run_latch_two_q && run_rise) begin
                run_latch_one_q <= 1'b1;
                run_latch_two_q <= 1'b1;
            end else begin
                if (t5 && halt_pend_q) begin
                    run_latch_one_q <= 1'b0;
                end
                if (t7 && !run_latch_one_q) begin
                    run_latch_two_q <= 1'b0;
                end
            end
            if (t7) begin
                // Phase 4 is left after one cycle; its work lies elsewhere
                fetch_phase_latch_q <= !interrupt_pending_i || int_phase_q;
                int_phase_q         <= interrupt_pending_i && !int_phase_q;
            end
        end
    end

    assign slot_o            = slot_q;
    assign program_counter_o = pc_q;
    assign memory_address_o  = mar_q;
    assign fetch_phase_o     = fetch_phase_latch_q;
    assign interrupt_phase_o = int_phase_q;
    assign run_latch_one_o   = run_latch_one_q;
    assign run_latch_two_o   = run_latch_two_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    opcode_load_a: assert property (
        t2 && fetch_phase_latch_q |=> opcode_latch_q == $past(fetched_word_latch_q[15:10]))
        else $error("opcode latch not loaded at T2");
    decode_window_a: assert property (
        io_group_decode_o |-> active && (slot_q >= 3'h3 || slot_q == 3'h0) && iog_match)
        else $error("group decode outside T3 to T0");
    decode_hold_a: assert property (
        io_group_decode_o && t3 |=> io_group_decode_o [*4])
        else $error("group decode dropped before T7");
    set_strobe_a: assert property (
        set_flag_strobe_o |-> slot_q == 3'h3 && fetched_word_latch_q[8:6] == 3'h1)
        else $error("set strobe at wrong slot or code");
    clear_strobe_a: assert property (
        io_group_decode_o && slot_q == 3'h4 && fetched_word_latch_q[9] |-> clear_flag_strobe_o)
        else $error("clear strobe missing at T4");
    select_gate_a: assert property (
        !io_group_decode_o |-> select_code_o == 6'h00)
        else $error("select code driven outside enable");
    carry_set_a: assert property (
        skip_test_strobe_o && flag_skip_response_i && slot_q == 3'h4
        |=> carry_latch_q ##1 carry_in_signal_o [*2])
        else $error("skip response did not reach carry-in");
    carry_clear_a: assert property (
        t0 && !(skip_test_strobe_o && flag_skip_response_i) |=> !carry_latch_q)
        else $error("carry latch survived T0");
    pc_step_a: assert property (
        counter_store_strobe_o && inject |=> mar_q == pc_q && pc_q != $past(pc_q)
        && pc_q == $past(pc_q) + ($past(carry_latch_q) ? 15'h0002 : 15'h0001))
        else $error("counter step wrong");
    loop_hold_a: assert property (
        counter_store_strobe_o && loop_sync_q |=> $stable(pc_q))
        else $error("loop mode moved the counter");
    halt_stop_a: assert property (
        halt_request_o |-> ##3 !run_latch_one_q ##2 !run_latch_two_q)
        else $error("halt did not drop run latches");
    phase_next_a: assert property (
        t7 && interrupt_pending_i && !int_phase_q |=> int_phase_q && !fetch_phase_latch_q)
        else $error("interrupt phase not entered");

endmodule

// *** rtl/ife_pkg.sv ***
package ife_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Word and field layout
    localparam int unsigned WORD_W    = 16;
    localparam int unsigned ADDR_W    = 15;
    localparam int unsigned SLOT_W    = 3;
    localparam int unsigned OPC_W     = 6;
    localparam int unsigned OPC_HI    = 15;
    localparam int unsigned OPC_LO    = 10;
    localparam int unsigned CLR_BIT   = 9;
    localparam int unsigned SUB_HI    = 8;
    localparam int unsigned SUB_LO    = 6;
    localparam int unsigned SEL_HI    = 5;
    localparam int unsigned SEL_LO    = 0;
    localparam int unsigned SEL_W     = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode latch pattern; bit 11 (A/B select) is a don't-care
    localparam logic [OPC_W-1:0] IOG_PATTERN = 6'h21;
    localparam logic [OPC_W-1:0] IOG_MASK    = 6'h3D;

    // Sub-operation codes in fetched-word bits 8..6
    localparam logic [2:0] SUB_HALT = 3'h0;
    localparam logic [2:0] SUB_FLAG = 3'h1;
    localparam logic [2:0] SUB_SKPC = 3'h2;

    // Whole halt word, octal 103001
    localparam logic [WORD_W-1:0] HALT_WORD = 16'h8601;

    ////////////////////////////////////////////////////////////////////////////
    // Machine-cycle slots
    localparam logic [SLOT_W-1:0] T0 = 3'h0;
    localparam logic [SLOT_W-1:0] T1 = 3'h1;
    localparam logic [SLOT_W-1:0] T2 = 3'h2;
    localparam logic [SLOT_W-1:0] T3 = 3'h3;
    localparam logic [SLOT_W-1:0] T4 = 3'h4;
    localparam logic [SLOT_W-1:0] T5 = 3'h5;
    localparam logic [SLOT_W-1:0] T6 = 3'h6;
    localparam logic [SLOT_W-1:0] T7 = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [OPC_W-1:0]  OPC_RST  = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [SLOT_W-1:0] SLOT_RST = 3'h0;

endpackage

// *** tb/ife_card_model.sv ***
`timescale 1ns/100ps

module ife_card_model (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // Strobes from the executor
    input  wire logic [5:0]  select_code_i,
    input  wire logic        set_flag_strobe_i,
    input  wire logic        clear_flag_strobe_i,
    input  wire logic        skip_test_strobe_i,
    // Answer and observation
    output logic             flag_skip_response_o,
    output logic      [63:0] flags_o
);
    logic [63:0] flag_q;
    logic        noise_q;

    // Response is a level; outside a test the line toggles so that a stale
    // value is never mistaken for an answer
    assign flag_skip_response_o = skip_test_strobe_i ?
        ~flag_q[select_code_i] : noise_q;
    assign flags_o              = flag_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            flag_q  <= 64'h0;
            noise_q <= 1'b0;
        end else begin
            noise_q <= ~noise_q;
            if (clear_flag_strobe_i) begin
                flag_q[select_code_i] <= 1'b0;
            end else if (set_flag_strobe_i) begin
                flag_q[select_code_i] <= 1'b1;
            end
        end
    end
endmodule

// *** tb/io_flag_instruction_exec_tb.sv ***
`timescale 1ns/100ps

module io_flag_instruction_exec_tb;
    logic        clk_sys_i, rst_n_i, run_press_i, loop_switch_i, interrupt_pending_i;
    logic [15:0] mem_word_i;
    logic [15:0] prog [0:31];
    logic [5:0]  select_code_o;
    logic [2:0]  slot_o;
    logic [14:0] program_counter_o, memory_address_o, exp_pc;
    logic [63:0] flags;
    logic        flag_skip_response_i, set_flag_strobe_o, clear_flag_strobe_o;
    logic        skip_test_strobe_o, io_group_decode_o, opcode_qualifier_o, halt_request_o;
    logic        counter_to_r_bus_o, increment_injection_o, adder_function_select_o;
    logic        carry_in_signal_o, counter_store_strobe_o, address_store_strobe_o;
    logic        fetch_phase_o, interrupt_phase_o, run_latch_one_o, run_latch_two_o;
    logic        exp_c, have_exp;
    logic [15:0] cur_w;
    int          fail_count, check_count, cycles;

    ife_exec u_dut (
        .clk_sys_i               (clk_sys_i),
        .rst_n_i                 (rst_n_i),
        .mem_word_i              (mem_word_i),
        .run_press_i             (run_press_i),
        .loop_switch_i           (loop_switch_i),
        .interrupt_pending_i     (interrupt_pending_i),
        .flag_skip_response_i    (flag_skip_response_i),
        .select_code_o           (select_code_o),
        .set_flag_strobe_o       (set_flag_strobe_o),
        .clear_flag_strobe_o     (clear_flag_strobe_o),
        .skip_test_strobe_o      (skip_test_strobe_o),
        .io_group_decode_o       (io_group_decode_o),
        .opcode_qualifier_o      (opcode_qualifier_o),
        .halt_request_o          (halt_request_o),
        .counter_to_r_bus_o      (counter_to_r_bus_o),
        .increment_injection_o   (increment_injection_o),
        .adder_function_select_o (adder_function_select_o),
        .carry_in_signal_o       (carry_in_signal_o),
        .counter_store_strobe_o  (counter_store_strobe_o),
        .address_store_strobe_o  (address_store_strobe_o),
        .slot_o                  (slot_o),
        .program_counter_o       (program_counter_o),
        .memory_address_o        (memory_address_o),
        .fetch_phase_o           (fetch_phase_o),
        .interrupt_phase_o       (interrupt_phase_o),
        .run_latch_one_o         (run_latch_one_o),
        .run_latch_two_o         (run_latch_two_o)
    );
    ife_card_model u_card (
        .clk_sys_i            (clk_sys_i),
        .rst_n_i              (rst_n_i),
        .select_code_i        (select_code_o),
        .set_flag_strobe_i    (set_flag_strobe_o),
        .clear_flag_strobe_i  (clear_flag_strobe_o),
        .skip_test_strobe_i   (skip_test_strobe_o),
        .flag_skip_response_o (flag_skip_response_i),
        .flags_o              (flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (fail_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wait_run(input logic v);
        int n;
        n = 0;
        while (run_latch_two_o !== v && n < 400) begin
            @(negedge clk_sys_i);
            n++;
        end
        check(16'(run_latch_two_o), 16'(v));
    endtask

    // Switch pin is synchronised, so it is held for several cycles
    task automatic press_run();
        run_press_i = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        run_press_i = 1'b0;
        wait_run(1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles >= 5000) begin
            fail_count++;
            final_report();
        end
    end

    assign cur_w = prog[program_counter_o[4:0]];

    always @(negedge clk_sys_i) begin
        mem_word_i <= cur_w;
    end

    // Per-slot watch of every fetch cycle against the word being executed
    always @(negedge clk_sys_i) begin
        if (rst_n_i && have_exp && slot_o === ife_pkg::T0) begin
            check(16'(program_counter_o), 16'(exp_pc));
            check(16'(memory_address_o), 16'(exp_pc));
            have_exp = 1'b0;
        end
        if (rst_n_i && run_latch_two_o === 1'b1 && fetch_phase_o === 1'b1) begin
            case (slot_o)
                ife_pkg::T3: begin
                    check(16'(io_group_decode_o & opcode_qualifier_o), 16'h0001);
                    check(16'(select_code_o), 16'(cur_w[5:0]));
                    check(16'(set_flag_strobe_o),
                          16'(cur_w[8:6] == ife_pkg::SUB_FLAG));
                    check(16'(skip_test_strobe_o),
                          16'(cur_w[8:6] == ife_pkg::SUB_SKPC));
                    check(16'(halt_request_o), 16'(cur_w[8:6] == ife_pkg::SUB_HALT));
                    exp_c = (cur_w[8:6] == ife_pkg::SUB_SKPC) && !flags[cur_w[5:0]];
                end
                ife_pkg::T4: begin
                    check(16'(clear_flag_strobe_o), 16'(cur_w[9]));
                end
                ife_pkg::T6: begin
                    check(16'(increment_injection_o), 16'(!loop_switch_i));
                    check(16'(carry_in_signal_o), 16'(exp_c));
                    check(16'(counter_to_r_bus_o & adder_function_select_o),
                          16'h0001);
                    exp_pc = program_counter_o + (loop_switch_i ? 15'h0000 : 15'h0001 + exp_c);
                    have_exp = 1'b1;
                end
                ife_pkg::T7: begin
                    check(16'(counter_store_strobe_o & address_store_strobe_o),
                          16'h0001);
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        fail_count = 0;
        check_count = 0;
        cycles = 0;
        have_exp = 1'b0;
        exp_c = 1'b0;
        exp_pc = 15'h0000;
        rst_n_i = 1'b0;
        run_press_i = 1'b0;
        loop_switch_i = 1'b0;
        interrupt_pending_i = 1'b1;
        for (int i = 0; i < 32; i++) begin
            prog[i] = ife_pkg::HALT_WORD;
        end
        // Set 1, set 5, test 5 (set), clear 5, test 5 (clear), skipped set 5, halt
        prog[0] = 16'h8441;
        prog[1] = 16'h8445;
        prog[2] = 16'h8485;
        prog[3] = 16'h8645;
        prog[4] = 16'h8485;
        prog[5] = 16'h8445;
        // Count rising edges so a time-zero clock event cannot shorten reset
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        @(negedge clk_sys_i);
        check(16'(program_counter_o), 16'h0000);
        check(16'({fetch_phase_o, run_latch_two_o, slot_o}), 16'h0010);
        press_run();
        while (slot_o !== ife_pkg::T7) @(negedge clk_sys_i);
        @(negedge clk_sys_i);
        interrupt_pending_i = 1'b0;
        check(16'({interrupt_phase_o, fetch_phase_o}), 16'h0002);
        check(16'(flags[1]), 16'h0001);
        wait_run(1'b0);
        repeat (3) @(negedge clk_sys_i);
        check(16'(program_counter_o), 16'h0007);
        check(16'({flags[5], flags[1]}), 16'h0000);
        check(16'({run_latch_one_o, run_latch_two_o, fetch_phase_o}), 16'h0001);
        // Looping halt stays put and repeats on each press
        loop_switch_i = 1'b1;
        repeat (2) begin
            repeat (4) @(negedge clk_sys_i);
            press_run();
            wait_run(1'b0);
            check(16'(program_counter_o), 16'h0007);
        end
        final_report();
    end
endmodule
